// *** design/aeih_pkg.sv ***
// Package of constants and carrier types for the axis external input block
package aeih_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int NUM_AXES = 4;
    localparam int OUT_BITS_WIDTH = 16;
    localparam int OUTS_PER_AXIS = 4;
    localparam int STOP_INPUTS = 4;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [15:0] OUT_BITS_RESET = 16'h0000;
    localparam int CLK_PERIOD_NS = 10;
    // Filter window when enabled, in nanoseconds, and in cycles
    localparam int FILTER_TIME_NS = 80;
    localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int FILTER_CNT_W = 4;

    // ------------------------------------------------------------------
    // Error status field positions
    // ------------------------------------------------------------------
    localparam int ERR_PLUS_LIMIT_BIT = 2;
    localparam int ERR_MINUS_LIMIT_BIT = 3;
    localparam int ERR_ALARM_BIT = 4;
    localparam int ERR_EMERGENCY_BIT = 5;
    localparam int ERR_WIDTH = 8;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        AEIH_EXT_OFF,
        AEIH_EXT_FIXED,
        AEIH_EXT_CONT,
        AEIH_EXT_PULSER
    } aeih_ext_mode_t;

    // Per-axis configuration; level bits: 1 means active high
    typedef struct packed {
        logic settled_enable;
        logic settled_level;
        logic fault_enable;
        logic fault_level;
        logic plus_limit_enable;
        logic minus_limit_enable;
        logic limit_level;
        logic limit_slow_stop;
        logic [3:0] stop_enable;
        logic [3:0] stop_level;
        logic stop_slow_stop;
        logic filter_enable;
        aeih_ext_mode_t ext_mode;
    } aeih_axis_cfg_t;

    // Raw external pins of one axis
    typedef struct packed {
        logic servo_settled_input;
        logic servo_fault_input;
        logic plus_overtravel_input;
        logic minus_overtravel_input;
        logic [3:0] axis_stop_inputs;
        logic external_plus_start;
        logic external_minus_start;
    } aeih_axis_pins_t;

    // Stop requests toward the pulse generator
    typedef struct packed {
        logic slow_stop;
        logic fast_stop;
    } aeih_stop_t;

    // Requests toward the drive and home logic
    typedef struct packed {
        logic start_plus;
        logic start_minus;
        logic run_plus;
        logic run_minus;
        logic pulser_a;
        logic pulser_b;
        logic near_home_signal;
        logic home_signal;
        logic encoder_index_signal;
    } aeih_drive_req_t;

    localparam int PIN_BITS = $bits(aeih_axis_pins_t);

endpackage

// *** design/aeih_input_cond.sv ***
// Two-stage synchroniser plus optional majority-free stability filter
`timescale 1ns/1ps
module aeih_input_cond #(
    parameter int WIDTH = 10,
    parameter int FILT_CYCLES = aeih_pkg::FILTER_CYCLES,
    parameter int CNT_W = aeih_pkg::FILTER_CNT_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Control
    input wire logic filter_enable,
    // Data
    input wire logic [WIDTH-1:0] raw_in,
    output logic [WIDTH-1:0] clean_out
);

    logic [WIDTH-1:0] sync1_reg;
    logic [WIDTH-1:0] sync2_reg;
    logic [WIDTH-1:0] clean_reg;
    logic [WIDTH-1:0] clean_next;
    logic [WIDTH-1:0][CNT_W-1:0] cnt_reg;
    logic [WIDTH-1:0][CNT_W-1:0] cnt_next;

    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILT_CYCLES - 1);

    // --------------------------------------------------------------
    // Filter: a change passes only after standing for the window
    // --------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            always_comb
            begin
                cnt_next[gi] = '0;
                clean_next[gi] = clean_reg[gi];
                if (!filter_enable)
                begin
                    clean_next[gi] = sync2_reg[gi];
                end
                else if (sync2_reg[gi] != clean_reg[gi])
                begin
                    if (cnt_reg[gi] >= CNT_LAST)
                    begin
                        clean_next[gi] = sync2_reg[gi];
                    end
                    else
                    begin
                        cnt_next[gi] = cnt_reg[gi] + CNT_W'(1);
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // Idle level of every external input is high (pulled up)
            sync1_reg <= '1;
            sync2_reg <= '1;
            clean_reg <= '1;
            cnt_reg <= '0;
        end
        else
        begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
            clean_reg <= clean_next;
            cnt_reg <= cnt_next;
        end
    end

    assign clean_out = clean_reg;

endmodule

// *** design/aeih_top.sv ***
// Per-axis external input handling and general outputs, four axes
// Function
// - Each axis general outputs follow its written output register bits.
// - Reset forces every general output low.
// - Output register write updates outputs with no axis selection.
// - With settle input enabled, running flag stays until settle input active or emergency.
// - Fault input enable and level selectable; sets alarm status bit.
// - Plus overtravel stops plus drive, slow or fast as configured.
// - Minus overtravel stops minus drive; stop type and level selectable.
// - Enabled active minus overtravel sets minus limit status bit.
// - Four stop inputs each enable and level; cause slow or fast stop.
// - Home search uses stop 0 near home, 1 home, 2 index.
// - Stop input levels readable in input status registers.
// - Fixed external mode starts drive on falling start input edge.
// - Continuous external mode drives while start input held low.
// - Pulser mode takes A phase from plus, B from minus start.
// - Low emergency input immediately stops every axis.
// - Emergency sets emergency bit in every axis error status.
// - Emergency input is fixed active low.
`timescale 1ns/1ps
module aeih_top #(
    parameter int NUM_AXES = aeih_pkg::NUM_AXES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // General output register write
    input wire logic out_write,
    input wire logic [NUM_AXES-1:0][15:0] output_bits_register,
    // Configuration
    input wire aeih_pkg::aeih_axis_cfg_t [NUM_AXES-1:0] axis_cfg,
    input wire logic emg_filter_enable,
    // Drive state from the pulse generator
    input wire logic [NUM_AXES-1:0] pulsing_plus,
    input wire logic [NUM_AXES-1:0] pulsing_minus,
    // External pins
    input wire aeih_pkg::aeih_axis_pins_t [NUM_AXES-1:0] axis_pins,
    input wire logic emergency_stop_n,
    // General outputs
    output logic [NUM_AXES-1:0][3:0] axis_general_outputs,
    // Status
    output logic [NUM_AXES-1:0] drive_running_flag,
    output logic [NUM_AXES-1:0][7:0] axis_error_status_register,
    output logic [NUM_AXES-1:0][3:0] input_status_stop_levels,
    output logic [NUM_AXES-1:0] plus_hw_limit_flag,
    output logic [NUM_AXES-1:0] minus_hw_limit_flag,
    output logic emergency_flag,
    // Requests toward drive logic
    output aeih_pkg::aeih_stop_t [NUM_AXES-1:0] stop_req,
    output aeih_pkg::aeih_drive_req_t [NUM_AXES-1:0] drive_req
);

    localparam int PB = aeih_pkg::PIN_BITS;

    logic emg_clean;
    logic emg_active;
    logic emg_reg;
    logic emg_next;

    // --------------------------------------------------------------
    // Emergency input: fixed active low, no level selection
    // --------------------------------------------------------------
    aeih_input_cond #(
        .WIDTH(1)
    ) u_emg_cond (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .filter_enable(emg_filter_enable),
        .raw_in(emergency_stop_n),
        .clean_out(emg_clean)
    );

    assign emg_active = !emg_clean;

    always_comb
    begin
        emg_next = emg_active;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            emg_reg <= 1'b0;
        end
        else
        begin
            emg_reg <= emg_next;
        end
    end

    assign emergency_flag = emg_reg;

    // --------------------------------------------------------------
    // Per-axis logic
    // --------------------------------------------------------------
    genvar ax;
    generate
        for (ax = 0; ax < NUM_AXES; ax++)
        begin : g_axis
            aeih_pkg::aeih_axis_pins_t clean;
            aeih_pkg::aeih_axis_cfg_t cfg;
            logic [PB-1:0] clean_bits;
            logic settled_act;
            logic fault_act;
            logic plus_act;
            logic minus_act;
            logic [3:0] stop_act;
            logic pulsing;
            logic [3:0] gout_reg;
            logic [3:0] gout_next;
            logic run_reg;
            logic run_next;
            logic [7:0] err_reg;
            logic [7:0] err_next;
            logic [3:0] lvl_reg;
            logic [3:0] lvl_next;
            logic plim_reg;
            logic plim_next;
            logic mlim_reg;
            logic mlim_next;
            logic plus_d_reg;
            logic minus_d_reg;
            aeih_pkg::aeih_stop_t stop_reg;
            aeih_pkg::aeih_stop_t stop_next;
            aeih_pkg::aeih_drive_req_t req_reg;
            aeih_pkg::aeih_drive_req_t req_next;

            assign cfg = axis_cfg[ax];
            assign pulsing = pulsing_plus[ax] | pulsing_minus[ax];

            aeih_input_cond #(
                .WIDTH(PB)
            ) u_cond (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .filter_enable(cfg.filter_enable),
                .raw_in(axis_pins[ax]),
                .clean_out(clean_bits)
            );

            assign clean = aeih_pkg::aeih_axis_pins_t'(clean_bits);

            // Level bit high selects active-high sense
            assign settled_act = cfg.settled_enable
                & (clean.servo_settled_input == cfg.settled_level);
            assign fault_act = cfg.fault_enable
                & (clean.servo_fault_input == cfg.fault_level);
            assign plus_act = cfg.plus_limit_enable
                & (clean.plus_overtravel_input == cfg.limit_level);
            assign minus_act = cfg.minus_limit_enable
                & (clean.minus_overtravel_input == cfg.limit_level);
            assign stop_act = cfg.stop_enable
                & ~(clean.axis_stop_inputs ^ cfg.stop_level);

            always_comb
            begin
                logic slow;
                logic fast;
                logic lim_hit;
                slow = 1'b0;
                fast = 1'b0;
                lim_hit = 1'b0;
                // Writes apply straight to this axis's field
                gout_next = gout_reg;
                if (out_write)
                begin
                    gout_next = output_bits_register[ax][3:0];
                end
                // With settle enabled, running flag holds past pulse end until servo settles or emergency
                run_next = run_reg;
                if (pulsing)
                begin
                    run_next = 1'b1;
                end
                else if (!cfg.settled_enable || settled_act || emg_active)
                begin
                    run_next = 1'b0;
                end
                err_next = 8'h00;
                err_next[aeih_pkg::ERR_ALARM_BIT] = fault_act;
                err_next[aeih_pkg::ERR_PLUS_LIMIT_BIT] = plus_act;
                err_next[aeih_pkg::ERR_MINUS_LIMIT_BIT] = minus_act;
                err_next[aeih_pkg::ERR_EMERGENCY_BIT] = emg_active;
                plim_next = plus_act;
                mlim_next = minus_act;
                lvl_next = clean.axis_stop_inputs;
                // Limit stops act only against the matching direction
                lim_hit = (plus_act & pulsing_plus[ax])
                    | (minus_act & pulsing_minus[ax]);
                if (lim_hit)
                begin
                    slow = cfg.limit_slow_stop;
                    fast = !cfg.limit_slow_stop;
                end
                if (|stop_act && pulsing)
                begin
                    slow = slow | cfg.stop_slow_stop;
                    fast = fast | !cfg.stop_slow_stop;
                end
                // Emergency overrides any slow request
                if (emg_active)
                begin
                    fast = 1'b1;
                    slow = 1'b0;
                end
                stop_next.slow_stop = slow;
                stop_next.fast_stop = fast;
                req_next = '0;
                req_next.near_home_signal = stop_act[0];
                req_next.home_signal = stop_act[1];
                req_next.encoder_index_signal = stop_act[2];
                case (cfg.ext_mode)
                    aeih_pkg::AEIH_EXT_FIXED:
                    begin
                        req_next.start_plus = plus_d_reg
                            & !clean.external_plus_start;
                        req_next.start_minus = minus_d_reg
                            & !clean.external_minus_start;
                    end
                    aeih_pkg::AEIH_EXT_CONT:
                    begin
                        req_next.run_plus = !clean.external_plus_start;
                        req_next.run_minus =
                            !clean.external_minus_start;
                    end
                    aeih_pkg::AEIH_EXT_PULSER:
                    begin
                        req_next.pulser_a = clean.external_plus_start;
                        req_next.pulser_b = clean.external_minus_start;
                    end
                    default:
                    begin
                        req_next.start_plus = 1'b0;
                    end
                endcase
                // No start or run request is passed during an emergency
                if (emg_active)
                begin
                    req_next.start_plus = 1'b0;
                    req_next.start_minus = 1'b0;
                    req_next.run_plus = 1'b0;
                    req_next.run_minus = 1'b0;
                end
            end

            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    gout_reg <= aeih_pkg::OUT_BITS_RESET[3:0];
                    run_reg <= 1'b0;
                    err_reg <= 8'h00;
                    lvl_reg <= 4'hF;
                    plim_reg <= 1'b0;
                    mlim_reg <= 1'b0;
                    plus_d_reg <= 1'b1;
                    minus_d_reg <= 1'b1;
                    stop_reg <= '0;
                    req_reg <= '0;
                end
                else
                begin
                    gout_reg <= gout_next;
                    run_reg <= run_next;
                    err_reg <= err_next;
                    lvl_reg <= lvl_next;
                    plim_reg <= plim_next;
                    mlim_reg <= mlim_next;
                    plus_d_reg <= clean.external_plus_start;
                    minus_d_reg <= clean.external_minus_start;
                    stop_reg <= stop_next;
                    req_reg <= req_next;
                end
            end

            assign axis_general_outputs[ax] = gout_reg;
            assign drive_running_flag[ax] = run_reg;
            assign axis_error_status_register[ax] = err_reg;
            assign input_status_stop_levels[ax] = lvl_reg;
            assign plus_hw_limit_flag[ax] = plim_reg;
            assign minus_hw_limit_flag[ax] = mlim_reg;
            assign stop_req[ax] = stop_reg;
            assign drive_req[ax] = req_reg;
        end
    endgenerate

endmodule

// *** dv/aeih_top_monitor.sv ***
// Port-level assertions for the axis external input block
`timescale 1ns/1ps
module aeih_top_monitor #(
    parameter int NUM_AXES = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Inputs watched
    input wire logic out_write,
    input wire logic [NUM_AXES-1:0][15:0] output_bits_register,
    input wire logic emg_filter_enable,
    input wire logic emergency_stop_n,
    // Outputs watched
    input wire logic [NUM_AXES-1:0][3:0] axis_general_outputs,
    input wire logic [NUM_AXES-1:0][7:0] axis_error_status_register,
    input wire logic [NUM_AXES-1:0] plus_hw_limit_flag,
    input wire logic [NUM_AXES-1:0] minus_hw_limit_flag,
    input wire logic emergency_flag,
    input wire aeih_pkg::aeih_stop_t [NUM_AXES-1:0] stop_req,
    input wire aeih_pkg::aeih_drive_req_t [NUM_AXES-1:0] drive_req
);
    logic [NUM_AXES-1:0][3:0] low_bits;
    logic [NUM_AXES-1:0] e_plus, e_minus, e_emg, fast, slow, moving;
    logic [NUM_AXES-1:0][1:0] starts;
    always_comb
    begin
        for (int i = 0; i < NUM_AXES; i++)
        begin
            low_bits[i] = output_bits_register[i][3:0];
            e_plus[i] = axis_error_status_register[i]
                [aeih_pkg::ERR_PLUS_LIMIT_BIT];
            e_minus[i] = axis_error_status_register[i]
                [aeih_pkg::ERR_MINUS_LIMIT_BIT];
            e_emg[i] = axis_error_status_register[i]
                [aeih_pkg::ERR_EMERGENCY_BIT];
            fast[i] = stop_req[i].fast_stop;
            slow[i] = stop_req[i].slow_stop;
            starts[i] = {drive_req[i].start_plus, drive_req[i].start_minus};
            moving[i] = |{starts[i], drive_req[i].run_plus,
                drive_req[i].run_minus};
        end
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    // Low level long enough to pass the synchroniser unfiltered
    sequence emg_held;
        $fell(emergency_stop_n) && !emg_filter_enable
            ##1 !emergency_stop_n [*3];
    endsequence
    a_out_load: assert property (out_write |=>
        axis_general_outputs == $past(low_bits))
        else $error("general outputs differ from written bits");
    a_out_hold: assert property (!out_write |=>
        $stable(axis_general_outputs))
        else $error("general outputs changed without a write");
    a_emg_latch: assert property (emg_held |=> emergency_flag)
        else $error("emergency input low but flag not raised");
    a_emg_stop: assert property (emergency_flag |->
        &fast && slow == '0 && moving == '0)
        else $error("axis not stopped at once during emergency");
    a_emg_bits: assert property (emergency_flag |-> &e_emg)
        else $error("emergency status bit missing on an axis");
    a_plus_flag: assert property (plus_hw_limit_flag == e_plus)
        else $error("plus limit flag and status bit disagree");
    a_minus_flag: assert property (minus_hw_limit_flag == e_minus)
        else $error("minus limit flag and status bit disagree");
    a_start_single: assert property ((starts & $past(starts)) == '0)
        else $error("start request longer than one cycle");
endmodule
bind aeih_top aeih_top_monitor #(.NUM_AXES(NUM_AXES)) u_monitor (
    .core_clk, .reset_n, .out_write, .output_bits_register,
    .emg_filter_enable, .emergency_stop_n, .axis_general_outputs,
    .axis_error_status_register, .plus_hw_limit_flag,
    .minus_hw_limit_flag, .emergency_flag, .stop_req, .drive_req
);

// *** dv/aeih_pin_model.sv ***
// Model of the switches, servo drivers and pulser on the axis pins
`timescale 1ns/1ps
module aeih_pin_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Requested levels
    input wire aeih_pkg::aeih_axis_pins_t [3:0] pins_want,
    input wire logic emg_want,
    // Pins
    output aeih_pkg::aeih_axis_pins_t [3:0] axis_pins,
    output logic emergency_stop_n
);
    logic [1:0] age;
    // A level must stand three clocks before the next change, so a
    // request that comes sooner waits, and only the latest one is applied
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            axis_pins <= '1;
            emergency_stop_n <= 1'b1;
            age <= 2'h0;
        end
        else if (age < 2'h2)
            age <= age + 2'h1;
        else if ({pins_want, emg_want} != {axis_pins, emergency_stop_n})
        begin
            axis_pins <= pins_want;
            emergency_stop_n <= emg_want;
            age <= 2'h0;
        end
    end
endmodule

// *** dv/aeih_top_tb.sv ***
// Self-checking bench for the axis external input block
`timescale 1ns/1ps
module aeih_top_tb;
    typedef struct {int sel; logic [31:0] exp;} aeih_note_t;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic out_write = 1'b0;
    logic [3:0][15:0] output_bits_register = '0;
    aeih_pkg::aeih_axis_cfg_t [3:0] axis_cfg = '0;
    logic emg_filter_enable = 1'b0;
    logic [3:0] pulsing_plus = '0;
    logic [3:0] pulsing_minus = '0;
    aeih_pkg::aeih_axis_pins_t [3:0] pins_want = '1;
    logic emg_want = 1'b1;
    aeih_pkg::aeih_axis_pins_t [3:0] axis_pins;
    logic emergency_stop_n;
    logic [3:0][3:0] axis_general_outputs;
    logic [3:0] drive_running_flag;
    logic [3:0][7:0] axis_error_status_register;
    logic [3:0][3:0] input_status_stop_levels;
    logic [3:0] plus_hw_limit_flag;
    logic [3:0] minus_hw_limit_flag;
    logic emergency_flag;
    aeih_pkg::aeih_stop_t [3:0] stop_req;
    aeih_pkg::aeih_drive_req_t [3:0] drive_req;
    aeih_note_t notes[$];
    aeih_note_t n;
    logic [31:0] seed = 32'h455B860F;
    logic [7:0] starts = 8'h00;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int due = 0;
    event probe;
    string names[10] = '{"gpo", "err", "stop", "lvl", "run", "home",
        "flag", "cont", "plsr", "start"};

    aeih_top dut (
        .core_clk, .reset_n, .out_write, .output_bits_register, .axis_cfg,
        .emg_filter_enable, .pulsing_plus, .pulsing_minus, .axis_pins,
        .emergency_stop_n, .axis_general_outputs, .drive_running_flag,
        .axis_error_status_register, .input_status_stop_levels,
        .plus_hw_limit_flag, .minus_hw_limit_flag, .emergency_flag,
        .stop_req, .drive_req
    );
    aeih_pin_model u_pins (
        .core_clk, .reset_n, .pins_want, .emg_want, .axis_pins,
        .emergency_stop_n
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] observe(int sel);
        case (sel)
            0: return 32'(axis_general_outputs);
            1: return axis_error_status_register;
            2: return 32'(stop_req);
            3: return 32'(input_status_stop_levels);
            4: return 32'(drive_running_flag);
            5: return 32'(drive_req[0][2:0]);
            6: return 32'({emergency_flag, plus_hw_limit_flag,
                minus_hw_limit_flag});
            7: return 32'({drive_req[0].run_plus, drive_req[0].run_minus});
            8: return 32'({drive_req[0].pulser_a, drive_req[0].pulser_b});
            default: return 32'(starts);
        endcase
    endfunction
    task automatic cyc(int k);
        repeat (k) @(negedge core_clk);
    endtask
    task automatic note(int sel, logic [31:0] exp);
        notes.push_back('{sel, exp});
    endtask
    task automatic look(int k);
        cyc(k);
        // Only notes made so far are due; later ones wait for their look
        due = notes.size();
        -> probe;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, result watcher and hang guard
    // ------------------------------------------------------------------
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    always @(probe)
    begin
        repeat (due)
        begin
            n = notes.pop_front();
            check(names[n.sel], observe(n.sel), n.exp);
        end
    end
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        // Requests are unknown until the first reset edge
        if (reset_n)
            starts <= starts + {3'h0, drive_req[0].start_minus, 3'h0,
                drive_req[0].start_plus};
        if (cycles == 2000)
        begin
            bad_count++;
            print_verdict();
        end
    end

    initial
    begin
        logic [63:0] d;
        cyc(3);
        note(0, 32'h0);
        look(0);
        reset_n = 1'b1;
        cyc(1);
        for (int i = 0; i < 3; i++)
        begin
            d = {rnd(), rnd()};
            output_bits_register = d;
            out_write = 1'b1;
            cyc(1);
        end
        out_write = 1'b0;
        output_bits_register = ~d;
        note(0, {16'h0, d[51:48], d[35:32], d[19:16], d[3:0]});
        look(3);
        axis_cfg[0].plus_limit_enable = 1'b1;
        axis_cfg[0].minus_limit_enable = 1'b1;
        for (int s = 0; s < 2; s++)
        begin
            axis_cfg[0].limit_slow_stop = s[0];
            pulsing_plus[0] = 1'b1;
            pins_want[0].plus_overtravel_input = 1'b0;
            note(2, s ? 32'h2 : 32'h1);
            note(6, 32'h10);
            look(8);
            pulsing_plus[0] = 1'b0;
            pulsing_minus[1:0] = 2'h3;
            pins_want[0] = '1;
            pins_want[0].minus_overtravel_input = 1'b0;
            pins_want[1].minus_overtravel_input = 1'b0;
            note(2, s ? 32'h2 : 32'h1);
            note(1, 32'h8);
            look(8);
            pulsing_minus = '0;
            pins_want = '1;
            note(1, 32'h0);
            look(8);
        end
        axis_cfg[2].fault_enable = 1'b1;
        pins_want[2].servo_fault_input = 1'b0;
        pins_want[3].servo_fault_input = 1'b0;
        note(1, 32'h0010_0000);
        look(8);
        pins_want = '1;
        axis_cfg[0].stop_enable = 4'hF;
        pulsing_plus[0] = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            pins_want[0].axis_stop_inputs = ~(4'h1 << k);
            note(3, {16'h0, 12'hFFF, ~(4'h1 << k)});
            note(2, 32'h1);
            note(5, 32'h4 >> k);
            look(8);
        end
        pins_want = '1;
        pulsing_plus = '0;
        axis_cfg[0].ext_mode = aeih_pkg::AEIH_EXT_CONT;
        pins_want[0].external_plus_start = 1'b0;
        note(7, 32'h2);
        look(8);
        axis_cfg[0].ext_mode = aeih_pkg::AEIH_EXT_PULSER;
        pins_want[0].external_plus_start = 1'b1;
        pins_want[0].external_minus_start = 1'b0;
        note(8, 32'h2);
        look(8);
        axis_cfg[0].ext_mode = aeih_pkg::AEIH_EXT_FIXED;
        pins_want[0] = '1;
        cyc(8);
        pins_want[0].external_plus_start = 1'b0;
        pins_want[0].external_minus_start = 1'b0;
        note(9, 32'h11);
        look(20);
        pins_want = '1;
        axis_cfg[1].settled_enable = 1'b1;
        pulsing_plus[1] = 1'b1;
        cyc(4);
        pulsing_plus[1] = 1'b0;
        note(4, 32'h2);
        look(8);
        pins_want[1].servo_settled_input = 1'b0;
        note(4, 32'h0);
        look(8);
        pins_want = '1;
        pulsing_plus = 4'hF;
        emg_want = 1'b0;
        note(6, 32'h100);
        note(1, 32'h2020_2020);
        note(2, 32'h55);
        look(8);
        emg_want = 1'b1;
        pulsing_plus = '0;
        axis_cfg[0].filter_enable = 1'b1;
        cyc(8);
        pins_want[0].plus_overtravel_input = 1'b0;
        cyc(1);
        pins_want[0] = '1;
        note(1, 32'h0);
        look(4);
        pins_want[0].plus_overtravel_input = 1'b0;
        note(1, 32'h4);
        look(20);
        cyc(1);
        print_verdict();
    end
endmodule
